//--- core/tcf_defines.svh
/*
  Register indices, field widths, reset values and mailbox bits for the
  transceiver control bank. Assumes one-word register access by index.
*/
`ifndef TCF_DEFINES_SVH
`define TCF_DEFINES_SVH

// ==========================================================
// Register indices
`define TCF_IDX_TX_POWER_DOWN 4'h0
`define TCF_IDX_TX_DRIVER_SWING 4'h1
`define TCF_IDX_TX_OUTPUT_INHIBIT 4'h2
`define TCF_IDX_TX_INVERT 4'h3
`define TCF_IDX_RX_INVERT 4'h4
`define TCF_IDX_RX_EQ_SELECT 4'h5
`define TCF_IDX_RX_EQ_RESET 4'h6
`define TCF_IDX_RX_BAD_HDR_LIMIT 4'h7
`define TCF_IDX_MBOX_ADDR 4'h8
`define TCF_IDX_MBOX_WDATA 4'h9
`define TCF_IDX_MBOX_CTRL 4'ha
`define TCF_IDX_MBOX_RDATA 4'hb

// ==========================================================
// Reset values
`define TCF_RST_TX_POWER_DOWN 2'h0
`define TCF_RST_TX_DRIVER_SWING 5'h08
`define TCF_RST_TX_OUTPUT_INHIBIT 1'h0
`define TCF_RST_TX_INVERT 1'h0
`define TCF_RST_RX_INVERT 1'h0
`define TCF_RST_RX_EQ_SELECT 1'h1
`define TCF_RST_RX_EQ_RESET 1'h0
`define TCF_RST_RX_BAD_HDR_LIMIT 4'h8

// ==========================================================
// Power-down codes and header limit range
`define TCF_PD_NORMAL 2'h0
`define TCF_PD_LOWEST 2'h3
`define TCF_HDR_LIMIT_MIN 4'h1
`define TCF_HDR_LIMIT_MAX 4'h8

// ==========================================================
// Mailbox control bits
`define TCF_MB_GO_BIT 0
`define TCF_MB_WRITE_BIT 1
`define TCF_MB_COMMON_BIT 2

`endif

//--- core/tcf_pkg.sv
/*
  Types for the transceiver control bank.
  Assumes tcf_defines.svh is not needed here; widths are fixed below.
*/
package tcf_pkg;

  // ========================================================
  // Mailbox sequencer
  typedef enum logic [1:0] {
    TCF_MB_IDLE = 2'b00,
    TCF_MB_WAIT = 2'b01
  } tcf_mb_e;

  // ========================================================
  // Config port request
  typedef struct packed {
    logic ch_en;
    logic cmn_en;
    logic we;
    logic [8:0] addr;
    logic [15:0] wdata;
  } tcf_cfg_req_s;

  // ========================================================
  // Whole block state
  typedef struct packed {
    logic [1:0] tx_power_down;
    logic [4:0] tx_driver_swing;
    logic tx_output_inhibit;
    logic tx_invert;
    logic rx_invert;
    logic rx_equalizer_select;
    logic rx_equalizer_reset;
    logic [3:0] rx_bad_header_limit;
    logic [3:0] bad_count;
    logic block_lock;
    logic serial_out_pos;
    logic serial_out_neg;
    logic rx_bit;
    logic [8:0] mb_addr;
    logic [15:0] mb_wdata;
    logic [15:0] mb_rdata;
    logic mb_write;
    logic mb_common;
    tcf_mb_e mb_state;
    tcf_cfg_req_s cfg;
    logic [31:0] rdata;
  } tcf_state_s;

endpackage : tcf_pkg

//--- core/tcf_bank.sv
/*
  Transceiver control field bank with config port mailbox, serial
  polarity and inhibit stage, and invalid sync header monitor.
  Assumes a simple indexed register port and a config port that
  answers with a one-cycle ready pulse.
*/
// Contract
// - Two-bit TX power-down, 00 normal, 11 lowest
// - Driver swing code, default 8, to transmitter
// - Inhibit forces positive low, negative high
// - TX invert swaps serial output sense
// - RX invert flips incoming serial data
// - Equalizer select resets to low-power mode
// - Drop block sync at programmable bad-header limit
// - Mailbox reaches common and channel config ports
`timescale 1ns/1ps
`default_nettype none
`include "tcf_defines.svh"

module tcf_bank (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Register port
  input wire logic REG_WR_I,
  input wire logic [3:0] REG_IDX_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  // Transmitter controls
  output logic [1:0] TX_POWER_DOWN_O,
  output logic [4:0] TX_DRIVER_SWING_O,
  // Serial data
  input wire logic TX_BIT_I,
  output logic SERIAL_OUT_POS_O,
  output logic SERIAL_OUT_NEG_O,
  input wire logic RX_BIT_I,
  output logic RX_BIT_O,
  // Receive equalizer
  output logic RX_EQUALIZER_SELECT_O,
  output logic RX_EQUALIZER_RESET_O,
  // Sync header monitor
  input wire logic RX_HDR_VALID_I,
  input wire logic RX_HDR_BAD_I,
  output logic RX_BLOCK_LOCK_O,
  // Config port
  output logic CFG_CMN_EN_O,
  output logic CFG_CH_EN_O,
  output logic CFG_WE_O,
  output logic [8:0] CFG_ADDR_O,
  output logic [15:0] CFG_WDATA_O,
  input wire logic [15:0] CFG_RDATA_I,
  input wire logic CFG_RDY_I
);

  // ========================================================
  // Helpers
  function automatic logic [3:0] clamp_limit(input logic [3:0] v);
    if (v < `TCF_HDR_LIMIT_MIN) begin
      clamp_limit = `TCF_HDR_LIMIT_MIN;
    end else if (v > `TCF_HDR_LIMIT_MAX) begin
      clamp_limit = `TCF_HDR_LIMIT_MAX;
    end else begin
      clamp_limit = v;
    end
  endfunction : clamp_limit

  function automatic logic wr_hit(input logic wr, input logic [3:0] idx, input logic [3:0] tgt);
    wr_hit = wr && (idx == tgt);
  endfunction : wr_hit

  tcf_pkg::tcf_state_s st;
  tcf_pkg::tcf_state_s next_st;
  logic [3:0] lim;
  logic mb_busy;

  // ========================================================
  // Next state
  always_comb begin
    next_st = st;
    lim = clamp_limit(st.rx_bad_header_limit);
    mb_busy = (st.mb_state != tcf_pkg::TCF_MB_IDLE);
    // Fields hold until rewritten
    if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_TX_POWER_DOWN)) begin
      next_st.tx_power_down = REG_WDATA_I[1:0];
    end
    if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_TX_DRIVER_SWING)) begin
      next_st.tx_driver_swing = REG_WDATA_I[4:0];
    end
    if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_TX_OUTPUT_INHIBIT)) begin
      next_st.tx_output_inhibit = REG_WDATA_I[0];
    end
    if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_TX_INVERT)) begin
      next_st.tx_invert = REG_WDATA_I[0];
    end
    if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_RX_INVERT)) begin
      next_st.rx_invert = REG_WDATA_I[0];
    end
    if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_RX_EQ_SELECT)) begin
      next_st.rx_equalizer_select = REG_WDATA_I[0];
    end
    if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_RX_EQ_RESET)) begin
      next_st.rx_equalizer_reset = REG_WDATA_I[0];
    end
    if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_RX_BAD_HDR_LIMIT)) begin
      next_st.rx_bad_header_limit = REG_WDATA_I[3:0];
    end
    if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_MBOX_ADDR) && !mb_busy) begin
      next_st.mb_addr = REG_WDATA_I[8:0];
    end
    if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_MBOX_WDATA) && !mb_busy) begin
      next_st.mb_wdata = REG_WDATA_I[15:0];
    end
    // Serial output stage
    if (st.tx_output_inhibit) begin
      next_st.serial_out_pos = 1'b0;
      next_st.serial_out_neg = 1'b1;
    end else begin
      next_st.serial_out_pos = TX_BIT_I ^ st.tx_invert;
      next_st.serial_out_neg = ~(TX_BIT_I ^ st.tx_invert);
    end
    next_st.rx_bit = RX_BIT_I ^ st.rx_invert;
    // Invalid sync header monitor
    if (RX_HDR_VALID_I) begin
      if (RX_HDR_BAD_I) begin
        if (st.bad_count + 4'h1 >= lim) begin
          next_st.block_lock = 1'b0;
          next_st.bad_count = 4'h0;
        end else begin
          next_st.bad_count = st.bad_count + 4'h1;
        end
      end else begin
        next_st.bad_count = 4'h0;
        next_st.block_lock = 1'b1;
      end
    end
    // Config port mailbox
    next_st.cfg.cmn_en = 1'b0;
    next_st.cfg.ch_en = 1'b0;
    case (st.mb_state)
      tcf_pkg::TCF_MB_IDLE: begin
        if (wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_MBOX_CTRL) && REG_WDATA_I[`TCF_MB_GO_BIT]) begin
          next_st.mb_write = REG_WDATA_I[`TCF_MB_WRITE_BIT];
          next_st.mb_common = REG_WDATA_I[`TCF_MB_COMMON_BIT];
          next_st.cfg.cmn_en = REG_WDATA_I[`TCF_MB_COMMON_BIT];
          next_st.cfg.ch_en = ~REG_WDATA_I[`TCF_MB_COMMON_BIT];
          next_st.cfg.we = REG_WDATA_I[`TCF_MB_WRITE_BIT];
          next_st.cfg.addr = st.mb_addr;
          next_st.cfg.wdata = st.mb_wdata;
          next_st.mb_state = tcf_pkg::TCF_MB_WAIT;
        end
      end
      tcf_pkg::TCF_MB_WAIT: begin
        if (CFG_RDY_I) begin
          if (!st.mb_write) begin
            next_st.mb_rdata = CFG_RDATA_I;
          end
          next_st.cfg.we = 1'b0;
          next_st.mb_state = tcf_pkg::TCF_MB_IDLE;
        end
      end
      default: begin
        next_st.mb_state = tcf_pkg::TCF_MB_IDLE;
      end
    endcase
    // Read mux
    case (REG_IDX_I)
      `TCF_IDX_TX_POWER_DOWN: next_st.rdata = {30'h0, st.tx_power_down};
      `TCF_IDX_TX_DRIVER_SWING: next_st.rdata = {27'h0, st.tx_driver_swing};
      `TCF_IDX_TX_OUTPUT_INHIBIT: next_st.rdata = {31'h0, st.tx_output_inhibit};
      `TCF_IDX_TX_INVERT: next_st.rdata = {31'h0, st.tx_invert};
      `TCF_IDX_RX_INVERT: next_st.rdata = {31'h0, st.rx_invert};
      `TCF_IDX_RX_EQ_SELECT: next_st.rdata = {31'h0, st.rx_equalizer_select};
      `TCF_IDX_RX_EQ_RESET: next_st.rdata = {31'h0, st.rx_equalizer_reset};
      `TCF_IDX_RX_BAD_HDR_LIMIT: next_st.rdata = {28'h0, st.rx_bad_header_limit};
      `TCF_IDX_MBOX_ADDR: next_st.rdata = {23'h0, st.mb_addr};
      `TCF_IDX_MBOX_WDATA: next_st.rdata = {16'h0, st.mb_wdata};
      `TCF_IDX_MBOX_CTRL: next_st.rdata = {27'h0, st.block_lock, mb_busy, st.mb_common,
                                           st.mb_write, 1'b0};
      `TCF_IDX_MBOX_RDATA: next_st.rdata = {16'h0, st.mb_rdata};
      default: next_st.rdata = 32'h0;
    endcase
  end

  // ========================================================
  // State register
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st <= '0;
      st.tx_power_down <= `TCF_RST_TX_POWER_DOWN;
      st.tx_driver_swing <= `TCF_RST_TX_DRIVER_SWING;
      st.tx_output_inhibit <= `TCF_RST_TX_OUTPUT_INHIBIT;
      st.tx_invert <= `TCF_RST_TX_INVERT;
      st.rx_invert <= `TCF_RST_RX_INVERT;
      st.rx_equalizer_select <= `TCF_RST_RX_EQ_SELECT;
      st.rx_equalizer_reset <= `TCF_RST_RX_EQ_RESET;
      st.rx_bad_header_limit <= `TCF_RST_RX_BAD_HDR_LIMIT;
      st.serial_out_neg <= 1'b1;
      st.mb_state <= tcf_pkg::TCF_MB_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================
  // Outputs
  assign REG_RDATA_O = st.rdata;
  assign TX_POWER_DOWN_O = st.tx_power_down;
  assign TX_DRIVER_SWING_O = st.tx_driver_swing;
  assign SERIAL_OUT_POS_O = st.serial_out_pos;
  assign SERIAL_OUT_NEG_O = st.serial_out_neg;
  assign RX_BIT_O = st.rx_bit;
  assign RX_EQUALIZER_SELECT_O = st.rx_equalizer_select;
  assign RX_EQUALIZER_RESET_O = st.rx_equalizer_reset;
  assign RX_BLOCK_LOCK_O = st.block_lock;
  assign CFG_CMN_EN_O = st.cfg.cmn_en;
  assign CFG_CH_EN_O = st.cfg.ch_en;
  assign CFG_WE_O = st.cfg.we;
  assign CFG_ADDR_O = st.cfg.addr;
  assign CFG_WDATA_O = st.cfg.wdata;

  // ========================================================
  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  inhibit_force_a: assert property (
    st.tx_output_inhibit |=> (!SERIAL_OUT_POS_O && SERIAL_OUT_NEG_O))
    else $error("Inhibit did not force serial lines");

  tx_polarity_a: assert property (
    !st.tx_output_inhibit |=>
      (SERIAL_OUT_POS_O == ($past(TX_BIT_I) ^ $past(st.tx_invert))) &&
      (SERIAL_OUT_NEG_O != SERIAL_OUT_POS_O))
    else $error("Serial output sense wrong");

  rx_polarity_a: assert property (
    ##1 RX_BIT_O == ($past(RX_BIT_I) ^ $past(st.rx_invert)))
    else $error("Receive bit polarity wrong");

  swing_write_a: assert property (
    wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_TX_DRIVER_SWING) |=>
      TX_DRIVER_SWING_O == $past(REG_WDATA_I[4:0]))
    else $error("Swing code not applied");

  power_hold_a: assert property (
    !wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_TX_POWER_DOWN) |=> $stable(TX_POWER_DOWN_O))
    else $error("Power-down field changed unwritten");

  eq_reset_hold_a: assert property (
    RX_EQUALIZER_RESET_O && !wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_RX_EQ_RESET) |=>
      RX_EQUALIZER_RESET_O)
    else $error("Equalizer reset cleared itself");

  sync_drop_a: assert property (
    RX_HDR_VALID_I && RX_HDR_BAD_I && (st.bad_count + 4'h1 >= lim) |=> !RX_BLOCK_LOCK_O)
    else $error("Block sync not dropped at limit");

  sync_keep_a: assert property (
    RX_HDR_VALID_I && RX_HDR_BAD_I && (st.bad_count + 4'h1 < lim) && RX_BLOCK_LOCK_O |=>
      RX_BLOCK_LOCK_O)
    else $error("Block sync dropped early");

  mbox_start_a: assert property (
    !mb_busy && wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_MBOX_CTRL) &&
      REG_WDATA_I[`TCF_MB_GO_BIT] |=>
      (CFG_CMN_EN_O ^ CFG_CH_EN_O) ##1 (!CFG_CMN_EN_O && !CFG_CH_EN_O))
    else $error("Mailbox enable not a single pulse");

  mbox_read_a: assert property (
    mb_busy && !st.mb_write && CFG_RDY_I |=> !mb_busy && st.mb_rdata == $past(CFG_RDATA_I))
    else $error("Mailbox read data not captured");

  power_write_a: assert property (
    wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_TX_POWER_DOWN) |=>
      TX_POWER_DOWN_O == $past(REG_WDATA_I[1:0]))
    else $error("Power-down code not applied");

  swing_hold_a: assert property (
    !wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_TX_DRIVER_SWING) |=> $stable(TX_DRIVER_SWING_O))
    else $error("Swing code changed unwritten");

  eq_select_hold_a: assert property (
    !wr_hit(REG_WR_I, REG_IDX_I, `TCF_IDX_RX_EQ_SELECT) |=> $stable(RX_EQUALIZER_SELECT_O))
    else $error("Equalizer select changed unwritten");

  lock_good_a: assert property (
    RX_HDR_VALID_I && !RX_HDR_BAD_I |=> RX_BLOCK_LOCK_O)
    else $error("Good header did not set lock");

  cfg_hold_a: assert property (
    mb_busy && !CFG_RDY_I |=>
      $stable(CFG_ADDR_O) && $stable(CFG_WDATA_O) && $stable(CFG_WE_O))
    else $error("Config request changed while pending");

  lock_drop_c: cover property (RX_BLOCK_LOCK_O ##1 !RX_BLOCK_LOCK_O);
  inhibit_c: cover property ($rose(st.tx_output_inhibit));
  mbox_done_c: cover property (mb_busy ##1 !mb_busy);
  eq_pulse_c: cover property ($rose(RX_EQUALIZER_RESET_O) ##[1:20] $fell(RX_EQUALIZER_RESET_O));

endmodule : tcf_bank
`default_nettype wire

//--- dv/tcf_cfg_model.sv
/*
  Config port partner: common and channel word maps, delayed ready pulse.
  Assumes one-cycle enables and request fields held until ready.
*/
`timescale 1ns/1ps
`default_nettype none
module tcf_cfg_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request
  input wire logic cmn_en_i,
  input wire logic ch_en_i,
  input wire logic we_i,
  input wire logic [8:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] delay_i,
  // Answer
  output logic [15:0] rdata_o,
  output logic rdy_o,
  output logic err_o
);
  // ========================================================
  // Word maps and pending request
  logic [15:0] cmem [512];
  logic [15:0] hmem [512];
  logic busy, cm, we_q;
  logic [8:0] a_q;
  logic [15:0] d_q;
  logic [3:0] cnt;
  initial begin
    for (int i = 0; i < 512; i++) begin
      cmem[i] = 16'(i) ^ 16'h1234;
      hmem[i] = 16'(i) ^ 16'hc0de;
    end
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      rdy_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 16'h5a5a;
    end else begin
      rdy_o <= 1'b0;
      // Idle bus inverts every bit of the last word each cycle
      rdata_o <= ~rdata_o;
      if (cmn_en_i || ch_en_i) begin
        busy <= 1'b1;
        cm <= cmn_en_i;
        we_q <= we_i;
        a_q <= addr_i;
        d_q <= wdata_i;
        cnt <= delay_i;
        if (busy || (cmn_en_i && ch_en_i)) err_o <= 1'b1;
      end else if (busy) begin
        if (we_i !== we_q || addr_i !== a_q || wdata_i !== d_q) err_o <= 1'b1;
        if (cnt != 4'h0) begin
          cnt <= cnt - 4'h1;
        end else begin
          busy <= 1'b0;
          rdy_o <= 1'b1;
          if (we_q && cm) cmem[a_q] <= d_q;
          if (we_q && !cm) hmem[a_q] <= d_q;
          rdata_o <= cm ? cmem[a_q] : hmem[a_q];
        end
      end
    end
  end
endmodule : tcf_cfg_model
`default_nettype wire

//--- dv/testbench.sv
/*
  Self-checking bench for the transceiver control bank.
  Assumes the config port partner model and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, wr, txb, rxb, hv, hb, ce, he, we, rdy, err;
  logic pos, neg, rxo, eqs, eqr, lock, cm, elock;
  logic [3:0] idx, dly, lim;
  logic [31:0] wd, rd, seed, r, v;
  logic [31:0] sh [16];
  logic [15:0] em [1024];
  bit ev [1024];
  logic [1:0] pd;
  logic [4:0] sw;
  logic [8:0] ad, a;
  logic [15:0] cwd, crd, q;
  int n_fail, checked, cnt;
  logic [31:0] msk [16] = '{3, 31, 1, 1, 1, 1, 1, 15, 0, 0, 0, 0, 0, 0, 0, 0};
  logic [31:0] rv [8] = '{0, 8, 0, 0, 0, 1, 0, 8};
  logic [3:0] lt [6] = '{0, 1, 8, 15, 2, 5};
  tcf_bank tcf_bank_i (.CLK_I(clk), .SYS_RST_I(rst), .REG_WR_I(wr), .REG_IDX_I(idx),
    .REG_WDATA_I(wd), .REG_RDATA_O(rd), .TX_POWER_DOWN_O(pd), .TX_DRIVER_SWING_O(sw),
    .TX_BIT_I(txb), .SERIAL_OUT_POS_O(pos), .SERIAL_OUT_NEG_O(neg), .RX_BIT_I(rxb),
    .RX_BIT_O(rxo), .RX_EQUALIZER_SELECT_O(eqs), .RX_EQUALIZER_RESET_O(eqr),
    .RX_HDR_VALID_I(hv), .RX_HDR_BAD_I(hb), .RX_BLOCK_LOCK_O(lock), .CFG_CMN_EN_O(ce),
    .CFG_CH_EN_O(he), .CFG_WE_O(we), .CFG_ADDR_O(ad), .CFG_WDATA_O(cwd),
    .CFG_RDATA_I(crd), .CFG_RDY_I(rdy));
  tcf_cfg_model tcf_cfg_model_i (.clk_i(clk), .rst_i(rst), .cmn_en_i(ce), .ch_en_i(he),
    .we_i(we), .addr_i(ad), .wdata_i(cwd), .delay_i(dly), .rdata_o(crd), .rdy_o(rdy),
    .err_o(err));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ========================================================
  // Helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function logic [15:0] iw(input logic c, input logic [8:0] x);
    return {7'h0, x} ^ (c ? 16'h1234 : 16'hc0de);
  endfunction : iw
  task complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wreg(input logic [3:0] i, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    idx = i;
    wd = d;
    sh[i] = d & msk[i];
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg
  task rreg(input logic [3:0] i, output logic [31:0] d);
    @(negedge clk);
    idx = i;
    @(negedge clk);
    d = rd;
  endtask : rreg
  task mbox(input logic c, input logic w, input logic [8:0] x, input logic [15:0] d);
    int n;
    n = 0;
    dly = rnd();
    wreg(4'h8, {23'h0, x});
    wreg(4'h9, {16'h0, d});
    wreg(4'ha, {29'h0, c, w, 1'b1});
    r = 32'h8;
    while (r[3] !== 1'b0 && n < 50) begin
      rreg(4'ha, r);
      n++;
    end
    if (r[3] !== 1'b0) begin
      n_fail++;
      complete_run();
    end
    rreg(4'hb, r);
    q = r[15:0];
  endtask : mbox
  // ========================================================
  // Main sequence
  initial begin
    seed = 11;
    rst = 1'b1;
    {wr, txb, rxb, hv, hb, elock} = '0;
    {idx, wd, dly} = '0;
    n_fail = 0;
    checked = 0;
    cnt = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk({pd, sw, eqs, eqr, lock, pos, neg}, 12'h111);
    for (int i = 0; i < 8; i++) begin
      rreg(i, r);
      chk(r, rv[i]);
      sh[i] = rv[i];
    end
    for (int k = 0; k < 24; k++) begin
      wreg(k % 8, rnd());
      rreg(k % 8, r);
      chk(r, sh[k % 8]);
      chk({pd, sw, eqs, eqr}, {sh[0][1:0], sh[1][4:0], sh[5][0], sh[6][0]});
    end
    wreg(4'hc, 32'hffff);
    rreg(4'hc, r);
    chk(r, 0);
    wreg(4'h5, 0);
    wreg(4'h6, 1);
    repeat (5) @(negedge clk);
    chk({eqs, eqr}, 2'b01);
    wreg(4'h6, 0);
    for (int k = 0; k < 48; k++) begin
      if (k % 8 == 0) for (int i = 2; i < 5; i++) wreg(i, rnd());
      r = rnd();
      txb = r[0];
      rxb = r[1];
      @(negedge clk);
      chk({pos, neg}, sh[2][0] ? 2'b01 : {r[0] ^ sh[3][0], ~(r[0] ^ sh[3][0])});
      chk(rxo, r[1] ^ sh[4][0]);
    end
    for (int j = 0; j < 6; j++) begin
      hv = 1'b0;
      wreg(4'h7, lt[j]);
      lim = lt[j] == 0 ? 1 : (lt[j] > 8 ? 8 : lt[j]);
      for (int k = 0; k < 20; k++) begin
        r = rnd();
        hv = 1'b1;
        hb = r[1:0] != 0;
        @(negedge clk);
        if (!hb) {cnt, elock} = {32'h0, 1'b1};
        else if (cnt + 1 >= lim) {cnt, elock} = {32'h0, 1'b0};
        else cnt++;
        chk(lock, elock);
      end
    end
    hv = 1'b0;
    wreg(4'h0, 3);
    chk(pd, 2'b11);
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      a = r[8:0];
      cm = r[9];
      mbox(cm, 1'b0, a, 16'h0);
      chk(q, ev[{cm, a}] ? em[{cm, a}] : iw(cm, a));
      v = rnd();
      em[{cm, a}] = {q[15:8], v[7:0]};
      ev[{cm, a}] = 1'b1;
      mbox(cm, 1'b1, a, {q[15:8], v[7:0]});
      mbox(!cm, 1'b0, a, 16'h0);
      chk(q, ev[{!cm, a}] ? em[{!cm, a}] : iw(!cm, a));
      mbox(cm, 1'b0, a, 16'h0);
      chk(q, em[{cm, a}]);
    end
    chk(err, 0);
    wreg(4'h0, 0);
    chk(pd, 2'b00);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk({sw, eqs, lock}, 7'h22);
    rst = 1'b0;
    rreg(4'h1, r);
    chk(r, 8);
    wreg(4'h1, 5);
    chk(sw, 5);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
